/* File: inc/fmc_pkg.sv */
package fmc_pkg;
   // -----------------------------------------------------------------
   // Field widths and positions.
   // -----------------------------------------------------------------
   localparam int FMC_WORD_W = 24;            // Three byte registers.
   localparam int FMC_ENABLE_A_BIT = 0;         // LSB of the low byte.
   localparam int FMC_REFDIV_W = 3;           // Reference divider field.
   localparam int FMC_MANT_W = 4;             // Deviation mantissa.
   localparam int FMC_EXP_W = 3;              // Deviation exponent.
   localparam int FMC_POWER_W = 8;            // Output power level.
   // -----------------------------------------------------------------
   // Synthesizer scaling.
   // -----------------------------------------------------------------
   localparam int FMC_LOW_DEN = 32768;        // Low band denominator.
   localparam int FMC_HIGH_DEN = 16384;       // High band denominator.
   localparam int FMC_LOW_EXP_BIAS = 16;      // Low band deviation bias.
   localparam int FMC_HIGH_EXP_BIAS = 15;     // High band deviation bias.
   // -----------------------------------------------------------------
   // Reset values and timing.
   // -----------------------------------------------------------------
   localparam logic [FMC_REFDIV_W-1:0] FMC_REFDIV_RST = 3'h1;
   localparam logic [FMC_POWER_W-1:0] FMC_POWER_RST = 8'h00;
   localparam int FMC_BIT_DIV_DEF = 64;       // Clock cycles per bit.
   localparam int FMC_GAUSS_TAPS = 4;         // Shaping filter length.
   localparam int FMC_FIFO_DEPTH = 8;         // Words in data FIFO.
   // -----------------------------------------------------------------
   // Data formats.
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      FMC_FMT_NRZ = 2'h0,
      FMC_FMT_MANCH = 2'h1,
      FMC_FMT_ASYNC = 2'h2
   } fmc_format_e;
   // Modulator states, one-hot.
   typedef enum logic [2:0] {
      FMC_ST_IDLE = 3'h1,
      FMC_ST_FIRST = 3'h2,
      FMC_ST_SECOND = 3'h4
   } fmc_state_e;
endpackage

/* File: hw/fmc_fifo.sv */
`timescale 1ns/1ns
// -------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides.
// -------------------------------------------------------------------
module fmc_fifo
   import fmc_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = FMC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];           // Storage array.
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;     // Pointers.
   logic [AW:0] cnt_q, cnt_d;                 // Fill level.
   logic push, pop;

   // Next pointer and level values.
   always_comb begin
      push = in_valid && (cnt_q != (AW+1)'(DEPTH));
      pop = (cnt_q != '0) && out_ready;
      wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Register pointers and the fill level.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   // Level never exceeds depth.
   chk_fifo_bound: assert property (
      @(posedge clk) disable iff (!reset_n)
      cnt_q <= (AW+1)'(DEPTH))
      else $error("fifo level above depth");
endmodule

/* File: hw/fmc_modulation_control.sv */
`timescale 1ns/1ns
// Operation
// - Two carrier words, main bit selects one.
// - Three bytes per word, LSB is enable_a.
// - Carrier scales by band denominator.
// - Band bit: low or high band.
// - Reference divider is three-bit field, 1..7.
// - Deviation: 4-bit mantissa, 3-bit exponent.
// - Data zero minus, one plus deviation.
// - Deviation scales by exponent bias per band.
// - Zero mantissa selects on-off keying.
// - Shaping bit enables Gaussian filtering.
// - Eight-bit output power setting.
// - Data delayed by sync and modulator.
// - Device drives bit clock, rising edge capture.
// - Manchester: zero rises, one falls.
module fmc_modulation_control
   import fmc_pkg::*;
#(
   parameter int BIT_DIV = FMC_BIT_DIV_DEF
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] freq_a_hi,           // Word A bytes.
   input wire logic [7:0] freq_a_mid,
   input wire logic [7:0] freq_a_lo,
   input wire logic [7:0] freq_b_hi,           // Word B bytes.
   input wire logic [7:0] freq_b_mid,
   input wire logic [7:0] freq_b_lo,
   input wire logic freq_select,               // 0 = word A, 1 = word B.
   input wire logic band_choice,               // 0 low band, 1 high band.
   input wire logic config_commit,             // Pulse: apply new words.
   input wire logic [FMC_REFDIV_W-1:0] ref_div_a,
   input wire logic [FMC_REFDIV_W-1:0] ref_div_b,
   input wire logic [FMC_MANT_W-1:0] deviation_mantissa,
   input wire logic [FMC_EXP_W-1:0] deviation_exponent,
   input wire logic shaping_enable,
   input wire logic [FMC_POWER_W-1:0] output_power_level,
   input wire logic [1:0] data_format,
   input wire logic tx_enable,
   input wire logic tx_bit_in,
   output logic bit_clock_out,
   output logic [FMC_WORD_W-2:0] synth_word,   // Word without enable_a.
   output logic synth_enable_a,
   output logic synth_band,
   output logic [FMC_REFDIV_W-1:0] synth_ref_div,
   output logic [FMC_MANT_W-1:0] dev_mantissa_out,
   output logic [FMC_EXP_W:0] dev_shift_out,   // Exponent plus band.
   output logic mod_freq_up,                    // 1 = carrier plus dev.
   output logic [FMC_POWER_W-1:0] pa_level_out,
   output logic ook_mode,
   output logic [FMC_GAUSS_TAPS:0] shaped_level,
   output logic fifo_full
);
   localparam int CW = $clog2(BIT_DIV);
   localparam logic [CW-1:0] HALF = CW'(BIT_DIV / 2 - 1);
   localparam logic [CW-1:0] LAST = CW'(BIT_DIV - 1);

   // -----------------------------------------------------------------
   // Synthesizer word shadowing.
   // -----------------------------------------------------------------
   logic [FMC_WORD_W-1:0] word_q, word_d;
   logic band_q, band_d;
   logic [FMC_REFDIV_W-1:0] rdiv_q, rdiv_d;
   logic [FMC_MANT_W-1:0] mant_q, mant_d;
   logic [FMC_EXP_W-1:0] exp_q, exp_d;
   logic [FMC_POWER_W-1:0] pwr_q, pwr_d;
   logic shape_q, shape_d;

   // Pick the active word and take it only on commit.
   always_comb begin
      word_d = word_q;
      band_d = band_q;
      rdiv_d = rdiv_q;
      mant_d = mant_q;
      exp_d = exp_q;
      shape_d = shape_q;
      pwr_d = output_power_level;
      if (config_commit) begin
         // Selection bit chooses between the two words.
         word_d = freq_select ?
            {freq_b_hi, freq_b_mid, freq_b_lo} :
            {freq_a_hi, freq_a_mid, freq_a_lo};
         band_d = band_choice;
         rdiv_d = freq_select ? ref_div_b : ref_div_a;
         mant_d = deviation_mantissa;
         exp_d = deviation_exponent;
         shape_d = shaping_enable;
      end
   end

   // Register the shadow set.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         word_q <= '0;
         band_q <= 1'b0;
         rdiv_q <= FMC_REFDIV_RST;
         mant_q <= '0;
         exp_q <= '0;
         shape_q <= 1'b0;
         pwr_q <= FMC_POWER_RST;
      end else begin
         word_q <= word_d;
         band_q <= band_d;
         rdiv_q <= rdiv_d;
         mant_q <= mant_d;
         exp_q <= exp_d;
         shape_q <= shape_d;
         pwr_q <= pwr_d;
      end
   end

   // -----------------------------------------------------------------
   // Bit clock divider.
   // -----------------------------------------------------------------
   logic [CW-1:0] div_q, div_d;
   logic bclk_q, bclk_d;
   logic rise;                                      // Capture enable.
   logic mid;                                       // Mid-bit enable.

   // Count a bit period; the bit clock rises at its start.
   always_comb begin
      div_d = (div_q == LAST) ? '0 : div_q + 1'b1;
      rise = tx_enable && (div_q == LAST);
      mid = tx_enable && (div_q == HALF);
      bclk_d = bclk_q;
      if (!tx_enable) begin
         div_d = '0;
         bclk_d = data_format[0];                   // Idle level.
      end else if (rise) begin
         bclk_d = 1'b1;
      end else if (mid) begin
         bclk_d = 1'b0;
      end
   end

   // Register the divider.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= '0;
         bclk_q <= 1'b0;
      end else begin
         div_q <= div_d;
         bclk_q <= bclk_d;
      end
   end

   // -----------------------------------------------------------------
   // Data capture and FIFO.
   // -----------------------------------------------------------------
   logic f_in_ready, f_out_valid, f_out_data;
   logic f_pop;

   // Bits are pushed at each bit clock rising edge, except in async format.
   fmc_fifo #(
      .WIDTH(1),
      .DEPTH(FMC_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(rise && data_format != FMC_FMT_ASYNC),
      .in_ready(f_in_ready),
      .in_data(tx_bit_in),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );

   // -----------------------------------------------------------------
   // Modulator sequencing.
   // -----------------------------------------------------------------
   fmc_state_e st_q, st_d;
   logic bit_q, bit_d;                              // Current bit.
   logic sym_q, sym_d;                              // Modulator symbol.
   logic full_q, full_d;

   // The next bit leaves the FIFO one bit period after capture.
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sym_d = sym_q;
      f_pop = 1'b0;
      full_d = !f_in_ready;
      unique case (st_q)
         FMC_ST_IDLE: begin
            if (rise && f_out_valid) begin
               f_pop = 1'b1;
               bit_d = f_out_data;
               st_d = FMC_ST_FIRST;
            end
         end
         FMC_ST_FIRST: begin
            // First half always carries the bit itself.
            sym_d = bit_q;
            if (mid) begin
               st_d = FMC_ST_SECOND;
            end
         end
         FMC_ST_SECOND: begin
            // Manchester second half inverts, so a zero rises.
            sym_d = (data_format == FMC_FMT_MANCH) ? !bit_q : bit_q;
            if (rise) begin
               st_d = FMC_ST_IDLE;
               if (f_out_valid) begin
                  f_pop = 1'b1;
                  bit_d = f_out_data;
                  st_d = FMC_ST_FIRST;
               end
            end
         end
      endcase
      if (data_format == FMC_FMT_ASYNC) begin
         sym_d = tx_bit_in;                         // Transparent mode.
      end
   end

   // Register the sequencer.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= FMC_ST_IDLE;
         bit_q <= 1'b0;
         sym_q <= 1'b0;
         full_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sym_q <= sym_d;
         full_q <= full_d;
      end
   end

   // -----------------------------------------------------------------
   // Gaussian shaping and output stage.
   // -----------------------------------------------------------------
   logic [FMC_GAUSS_TAPS-1:0] tap_q, tap_d;
   logic [FMC_GAUSS_TAPS:0] lvl_q, lvl_d;
   logic up_q, up_d, ook_q, ook_d;
   logic [FMC_EXP_W:0] shift_q, shift_d;

   // Moving sum of recent symbols approximates the Gaussian pulse.
   always_comb begin
      tap_d = {tap_q[FMC_GAUSS_TAPS-2:0], sym_q};
      lvl_d = '0;
      for (int i = 0; i < FMC_GAUSS_TAPS; i++) begin
         lvl_d = lvl_d + (FMC_GAUSS_TAPS+1)'(tap_q[i]);
      end
      if (!shape_q) begin
         lvl_d = sym_q ? (FMC_GAUSS_TAPS+1)'(FMC_GAUSS_TAPS) : '0;
      end
      up_d = sym_q;
      ook_d = (mant_q == '0);
      // High band bias is one less, so shift one more; the extra bit
      // keeps exponent 7 in the high band from wrapping to zero.
      shift_d = {1'b0, exp_q} + (FMC_EXP_W+1)'(band_q);
   end

   // Register the output stage.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tap_q <= '0;
         lvl_q <= '0;
         up_q <= 1'b0;
         ook_q <= 1'b1;
         shift_q <= '0;
      end else begin
         tap_q <= tap_d;
         lvl_q <= lvl_d;
         up_q <= up_d;
         ook_q <= ook_d;
         shift_q <= shift_d;
      end
   end

   // All outputs are flip-flops.
   assign bit_clock_out = bclk_q;
   assign synth_word = word_q[FMC_WORD_W-1:1];
   assign synth_enable_a = word_q[FMC_ENABLE_A_BIT];
   assign synth_band = band_q;
   assign synth_ref_div = rdiv_q;
   assign dev_mantissa_out = mant_q;
   assign dev_shift_out = shift_q;
   assign mod_freq_up = up_q;
   assign pa_level_out = pwr_q;
   assign ook_mode = ook_q;
   assign shaped_level = lvl_q;
   assign fifo_full = full_q;

   // -----------------------------------------------------------------
   // Checks.
   // -----------------------------------------------------------------
   chk_word_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !config_commit |=> $stable(word_q))
      else $error("word changed without commit");
   chk_word_pick: assert property (
      @(posedge clk) disable iff (!reset_n)
      config_commit && freq_select |=>
      word_q == {$past(freq_b_hi), $past(freq_b_mid), $past(freq_b_lo)})
      else $error("word B not taken");
   chk_ook_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      mant_q == '0 |=> ook_mode)
      else $error("ook not set on zero mantissa");
   chk_dev_band: assert property (
      @(posedge clk) disable iff (!reset_n)
      band_q |=> dev_shift_out == (FMC_EXP_W+1)'($past(exp_q)) + 1'b1)
      else $error("high band shift wrong");
   chk_sym_dir: assert property (
      @(posedge clk) disable iff (!reset_n)
      ##1 mod_freq_up == $past(sym_q))
      else $error("deviation direction wrong");
   chk_bclk_rise: assert property (
      @(posedge clk) disable iff (!reset_n)
      rise |=> bit_clock_out)
      else $error("bit clock not high after capture");
   chk_manch_half: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_q == FMC_ST_SECOND && data_format == FMC_FMT_MANCH
      |=> sym_q == !$past(bit_q))
      else $error("manchester second half wrong");
   chk_enable_a_bit: assert property (
      @(posedge clk) disable iff (!reset_n)
      config_commit |=> synth_enable_a ==
      $past(freq_select ? freq_b_lo[0] : freq_a_lo[0]))
      else $error("enable_a bit misplaced");
   chk_power_path: assert property (
      @(posedge clk) disable iff (!reset_n)
      ##1 pa_level_out == $past(output_power_level))
      else $error("power level not passed");
endmodule

/* File: tb/fmc_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host model: feeds frame bits on the bit clock, ramps power.
// ------------------------------------------------------------
module fmc_host_model
   import fmc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bit_clock_out,
   input wire logic send,
   input wire logic [15:0] frame,
   input wire logic ramp,
   input wire logic [FMC_POWER_W-1:0] target,
   output logic tx_bit_in,
   output logic [FMC_POWER_W-1:0] output_power_level,
   output logic busy
);
   logic prev_clk; // Bit clock one cycle ago.
   logic ramping; // A power ramp is running.
   int idx; // Index of the bit now on the line.
   // Bits change after a falling bit clock, so they are settled at
   // the rise that captures them.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_clk <= 1'b0;
         busy <= 1'b0;
         idx <= 0;
         tx_bit_in <= 1'b0;
      end else begin
         prev_clk <= bit_clock_out;
         if (send) begin
            busy <= 1'b1;
            idx <= -1;
         end else if (!busy) begin
            // A released line toggles so no stale level is left.
            tx_bit_in <= ~tx_bit_in;
         end else if (prev_clk && !bit_clock_out) begin
            idx <= idx + 1;
            tx_bit_in <= (idx + 1 < 16) ? frame[idx + 1] : ~tx_bit_in;
            // The frame closes only after two further bit periods.
            if (idx == 17) begin
               busy <= 1'b0;
            end
         end
      end
   end
   // Linear ramp: 00h up to 0Fh, then 50h up to the target.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         output_power_level <= FMC_POWER_RST;
         ramping <= 1'b0;
      end else if (ramp) begin
         output_power_level <= 8'h00;
         ramping <= 1'b1;
      end else if (ramping) begin
         if (output_power_level == 8'h0f) begin
            output_power_level <= 8'h50;
         end else if (output_power_level < 8'h0f ||
                      output_power_level < target) begin
            output_power_level <= output_power_level + 8'h01;
         end else begin
            ramping <= 1'b0;
         end
      end
   end
endmodule

/* File: tb/fmc_modulation_control_tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) cmp(64'(a), 64'(e))
module fmc_modulation_control_tb
   import fmc_pkg::*;
;
   localparam int BD = 8; // Short bit period for simulation.
   logic clk = 1'b0, reset_n = 1'b0, config_commit = 1'b0;
   logic [7:0] freq_a_hi = '0, freq_a_mid = '0, freq_a_lo = '0;
   logic [7:0] freq_b_hi = '0, freq_b_mid = '0, freq_b_lo = '0;
   logic freq_select = 1'b0, band_choice = 1'b0, shaping_enable = 1'b0;
   logic [2:0] ref_div_a = 3'h1, ref_div_b = 3'h1;
   logic [3:0] deviation_mantissa = '0;
   logic [2:0] deviation_exponent = '0;
   logic [1:0] data_format = '0;
   logic tx_enable = 1'b0, tx_bit_in, tb_bit = 1'b0, host_bit, busy;
   logic send = 1'b0, ramp = 1'b0;
   logic [15:0] frame = '0;
   logic [7:0] target = 8'h50, output_power_level, pa_level_out;
   logic bit_clock_out, synth_enable_a, synth_band, mod_freq_up;
   logic ook_mode, fifo_full;
   logic [22:0] synth_word;
   logic [2:0] synth_ref_div;
   logic [3:0] dev_shift_out;
   logic [3:0] dev_mantissa_out;
   logic [4:0] shaped_level;
   logic trace[$]; // Deviation direction (mod_freq_up), one entry per cycle.
   int fail_count = 0, checks = 0;
   // Async mode lets the bench drive the data pin directly.
   assign tx_bit_in = (data_format == 2'h2) ? tb_bit : host_bit;
   always #4 clk = ~clk;
   fmc_modulation_control #(.BIT_DIV(BD)) i_fmc_modulation_control (
      .clk, .reset_n, .freq_a_hi, .freq_a_mid, .freq_a_lo, .freq_b_hi,
      .freq_b_mid, .freq_b_lo, .freq_select, .band_choice, .config_commit,
      .ref_div_a, .ref_div_b, .deviation_mantissa, .deviation_exponent,
      .shaping_enable, .output_power_level, .data_format, .tx_enable,
      .tx_bit_in, .bit_clock_out, .synth_word, .synth_enable_a, .synth_band,
      .synth_ref_div, .dev_mantissa_out, .dev_shift_out, .mod_freq_up,
      .pa_level_out, .ook_mode, .shaped_level, .fifo_full);
   fmc_host_model i_fmc_host_model (.clk, .reset_n, .bit_clock_out, .send,
      .frame, .ramp, .target, .tx_bit_in(host_bit), .output_power_level,
      .busy);
   // Compares and counts; reports a mismatch at once.
   task automatic cmp(input logic [63:0] a, input logic [63:0] e);
      checks++;
      if (a !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, a, e);
      end
   endtask
   // Moves to just after the n-th next rising edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Exponent as the synthesizer uses it: one more in the high band.
   function automatic logic [3:0] exp_shift(input logic [2:0] x,
                                            input logic b);
      return {1'b0, x} + 4'(b);
   endfunction
   // Looks for the frame in the trace at any bit alignment.
   function automatic bit found(input int f, input logic [15:0] fr);
      bit ok;
      for (int o = 0; o + 16 * BD <= trace.size(); o++) begin
         ok = 1'b1;
         for (int i = 0; i < 16; i++) begin
            if (trace[o + i * BD + 2] !== fr[i]) ok = 1'b0;
            if (trace[o + i * BD + 6] !== (f[0] ? ~fr[i] : fr[i])) ok = 1'b0;
         end
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction
   // Random settings; bytes that change without a commit are ignored.
   task automatic config_test();
      logic [23:0] wa, wb, w;
      for (int i = 0; i < 24; i++) begin
         wa = 24'($urandom);
         wb = 24'($urandom);
         if (i % 2 == 0) wa[FMC_ENABLE_A_BIT] = 1'b1;
         {freq_a_hi, freq_a_mid, freq_a_lo} = wa;
         {freq_b_hi, freq_b_mid, freq_b_lo} = wb;
         freq_select = 1'($urandom);
         band_choice = 1'($urandom);
         ref_div_a = 3'($urandom_range(7, 1));
         ref_div_b = 3'($urandom_range(7, 1));
         deviation_mantissa = (i % 4 == 0) ? 4'h0 : 4'($urandom);
         deviation_exponent = (i % 3 == 0) ? 3'h7 : 3'($urandom);
         config_commit = 1'b1;
         step(1);
         config_commit = 1'b0;
         w = freq_select ? wb : wa;
         `CHK(synth_word, w[23:1]);
         `CHK(synth_enable_a, w[FMC_ENABLE_A_BIT]);
         `CHK(synth_band, band_choice);
         `CHK(synth_ref_div, freq_select ? ref_div_b : ref_div_a);
         `CHK(dev_mantissa_out, deviation_mantissa);
         step(1);
         `CHK(ook_mode, deviation_mantissa == 4'h0);
         `CHK(dev_shift_out, exp_shift(deviation_exponent, band_choice));
         {freq_a_hi, freq_a_mid, freq_a_lo} = ~wa;
         {freq_b_hi, freq_b_mid, freq_b_lo} = ~wb;
         band_choice = ~band_choice;
         freq_select = ~freq_select;
         step(2);
         `CHK(synth_word, w[23:1]);
         `CHK(synth_band, !band_choice);
      end
      $display("config test done");
   endtask
   initial begin
      int n, lastr;
      logic pbc;
      logic [1:0] h;
      logic [7:0] prev;
      void'($urandom(84201));
      step(8);
      `CHK(synth_ref_div, FMC_REFDIV_RST);
      `CHK(ook_mode, 1'b1);
      `CHK(pa_level_out, FMC_POWER_RST);
      reset_n = 1'b1;
      step(1);
      config_test();
      // Power ramp: the level reaches the pins one cycle later.
      target = 8'h50 + 8'($urandom_range(175));
      ramp = 1'b1;
      step(1);
      ramp = 1'b0;
      prev = output_power_level;
      for (int i = 0; i < 200; i++) begin
         step(1);
         `CHK(pa_level_out, prev);
         prev = output_power_level;
      end
      `CHK(pa_level_out, target);
      $display("power test done");
      // Idle bit clock level follows the low format bit.
      for (int f = 0; f < 2; f++) begin
         data_format = 2'(f);
         step(3);
         `CHK(bit_clock_out, f[0]);
      end
      // FSK with shaping, async data straight through.
      deviation_mantissa = 4'h5;
      shaping_enable = 1'b1;
      config_commit = 1'b1;
      step(1);
      config_commit = 1'b0;
      data_format = 2'h2;
      tx_enable = 1'b1;
      for (int i = 0; i < 200; i++) begin
         if (i > 2) `CHK(mod_freq_up, h[1]);
         h[1] = h[0];
         h[0] = (i < 100) ? 1'($urandom) : 1'(i < 150);
         tb_bit = h[0];
         step(1);
         if (i == 149) `CHK(shaped_level, 5'h04);
      end
      `CHK(shaped_level, 5'h00);
      $display("async test done");
      // Synchronous NRZ then Manchester frames from the host model.
      for (int f = 0; f < 2; f++) begin
         data_format = 2'(f);
         frame = 16'($urandom);
         trace.delete();
         send = 1'b1;
         step(1);
         send = 1'b0;
         n = 0;
         lastr = -1;
         pbc = bit_clock_out;
         while ((busy === 1'b1 || n < 3 * BD) && n < 2000) begin
            trace.push_back(mod_freq_up);
            if (bit_clock_out && !pbc) begin
               if (lastr >= 0) `CHK(n - lastr, BD);
               lastr = n;
            end
            if (busy !== 1'b1) n = n + 1;
            pbc = bit_clock_out;
            `CHK(fifo_full, 1'b0);
            step(1);
            if (busy === 1'b1) n = n + 1;
         end
         `CHK(found(f, frame), 1'b1);
      end
      $display("sync test done");
      // Stopped bit clock: idle level, nothing more leaves the buffer.
      tx_enable = 1'b0;
      step(3);
      pbc = mod_freq_up;
      for (int i = 0; i < 40; i++) begin
         step(1);
         `CHK(mod_freq_up, pbc);
         `CHK(fifo_full, 1'b0);
      end
      `CHK(bit_clock_out, data_format[0]);
      $display("stop test done");
      end_of_test();
   end
   // Watchdog: far beyond the expected run of under a thousand cycles.
   initial begin
      #(8 * 20000);
      fail_count++;
      $display("watchdog expired");
      end_of_test();
   end
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
endmodule
